// File: rmfs_pkg.sv
// Purpose: shared constants for the relay matrix command sequencer
// Assumes: 40 MHz system clock
// Notes: timing counts derive from printed times
package rmfs_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int COIL_PULSE_MS = 7;
  localparam int COIL_PULSE_CYC = (CLK_HZ / 1000) * COIL_PULSE_MS;
  // ==========================================================
  // widths and sizes
  localparam int BANK_W = 16;        // relays per bank
  localparam int ADDR_W = 4;         // bank address width
  localparam int NUM_BANKS = 16;     // 256 relays in densest build
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int CNT_W = 24;
endpackage : rmfs_pkg

// File: rmfs_sequencer.sv
// Purpose: relay matrix command path, fifo capture and coil sequencing
// Assumes: bus strobes synchronous to clk_sys, one clock domain
// Notes: one coil pulse per bank entry, one interrupt per command list
//
// Summary of operation
// RULE_01: every command word written while the fifo is not full enters the fifo with bank address.
// RULE_02: acknowledge the bus write as soon as the word is stored.
// RULE_03: after acknowledge, the sequencer is started on queued commands.
// RULE_04: while fifo not empty, pop entries and pulse coils for 7 ms.
// RULE_05: one pulse per bank sets all sixteen relays together.
// RULE_06: keep reading entries until the empty flag shows none remain.
// RULE_07: when empty and last pulse done, raise the interrupt request.
// RULE_08: only one interrupt per complete list, not per relay operation.
// RULE_09: after reset drive every relay bank to the open state.
// RULE_10: coil drive is applied only during pulses, never held on.
// RULE_11: interrupt holds until acknowledged; a new write clears it.
// RULE_12: pulse width timed by a counter with a parameter count.
`timescale 1ns/100ps
module rmfs_sequencer #(
  parameter int PULSE_CYC = rmfs_pkg::COIL_PULSE_CYC,
  parameter int DEPTH = rmfs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // bus write side
  input wire logic wr_strobe,
  input wire logic [rmfs_pkg::ADDR_W-1:0] wr_bank,
  input wire logic [rmfs_pkg::BANK_W-1:0] wr_data,
  output logic wr_ack,
  output logic wr_full,
  // interrupt to commander
  output logic irq_req_n,
  input wire logic irq_ack,
  // coil drivers
  output logic [rmfs_pkg::BANK_W-1:0] coil_set,
  output logic [rmfs_pkg::BANK_W-1:0] coil_reset,
  output logic [rmfs_pkg::NUM_BANKS-1:0] bank_sel,
  output logic busy
);
  import rmfs_pkg::*;

  typedef enum logic [1:0] {RMFS_IDLE, RMFS_POP, RMFS_PULSE} rmfs_state_e;

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // one-hot bank decode, used for pulses and reset sweep
  function automatic logic [NUM_BANKS-1:0] bank_dec(
    input logic [ADDR_W-1:0] a);
    bank_dec = '0;
    bank_dec[a] = 1'b1;
  endfunction : bank_dec

  // ==========================================================
  // command fifo
  logic [BANK_W+ADDR_W-1:0] mem [DEPTH];
  logic [FIFO_AW:0] wptr;
  logic [FIFO_AW:0] rptr;
  logic fifo_empty_n;
  logic do_push;
  logic do_pop;
  assign fifo_empty_n = (wptr != rptr);
  assign wr_full = (wptr[FIFO_AW] != rptr[FIFO_AW]) &&
                   (wptr[FIFO_AW-1:0] == rptr[FIFO_AW-1:0]);
  assign do_push = wr_strobe && !wr_full;

  // RULE_01 capture command word
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wptr[FIFO_AW-1:0]] <= {wr_bank, wr_data};
    end
  end

  // fifo pointers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  // ==========================================================
  // bus acknowledge and start request
  logic start_req;
  // RULE_02 ack once stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ack <= 1'b0;
    end else begin
      wr_ack <= do_push;  // one-cycle pulse after storage edge
    end
  end
  // RULE_03 start after ack
  assign start_req = wr_ack;

  // ==========================================================
  // sequencer
  rmfs_state_e state;
  logic [CNT_W-1:0] pulse_cnt;
  logic [ADDR_W-1:0] cur_bank;
  logic [BANK_W-1:0] cur_data;
  logic init_sweep;             // reset open sweep in progress
  logic [ADDR_W-1:0] sweep_bank;
  logic list_done;
  logic armed;                  // a list is running since a stored write
  // count ends one past the last drive cycle, so coils stand PULSE_CYC cycles
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC);

  // RULE_06 pop while entries remain
  assign do_pop = (state == RMFS_POP) && fifo_empty_n && !init_sweep;

  // state machine, reset sweep first, then fifo entries
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= RMFS_IDLE;
      pulse_cnt <= '0;
      cur_bank <= '0;
      cur_data <= '0;
      init_sweep <= 1'b1;
      sweep_bank <= '0;
      list_done <= 1'b0;
    end else begin
      list_done <= 1'b0;
      case (state)
        RMFS_IDLE: begin
          // RULE_09 open all banks
          if (init_sweep) begin
            cur_bank <= sweep_bank;
            cur_data <= '0;
            pulse_cnt <= '0;
            state <= RMFS_PULSE;
          end else if (start_req || fifo_empty_n) begin
            state <= RMFS_POP;
          end
        end
        RMFS_POP: begin
          // RULE_04 pop entry
          if (fifo_empty_n) begin
            cur_bank <= mem[rptr[FIFO_AW-1:0]][BANK_W+ADDR_W-1:BANK_W];
            cur_data <= mem[rptr[FIFO_AW-1:0]][BANK_W-1:0];
            pulse_cnt <= '0;
            state <= RMFS_PULSE;
          end else begin
            // RULE_07 empty after last pulse
            list_done <= 1'b1;
            state <= RMFS_IDLE;
          end
        end
        RMFS_PULSE: begin
          // RULE_12 pulse width counter
          if (pulse_cnt == PULSE_LAST) begin
            pulse_cnt <= '0;
            if (init_sweep) begin
              sweep_bank <= sweep_bank + 1'b1;
              if (sweep_bank == ADDR_W'(NUM_BANKS - 1)) begin
                init_sweep <= 1'b0;
              end
              state <= RMFS_IDLE;
            end else begin
              state <= RMFS_POP;
            end
          end else begin
            pulse_cnt <= pulse_cnt + 1'b1;
          end
        end
        default: begin
          state <= RMFS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // coil drive outputs
  // RULE_05 whole bank per pulse
  // RULE_10 drive only in pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coil_set <= '0;
      coil_reset <= '0;
      bank_sel <= '0;
    end else if (state == RMFS_PULSE && pulse_cnt != PULSE_LAST) begin
      coil_set <= cur_data;
      coil_reset <= ~cur_data;
      bank_sel <= bank_dec(cur_bank);
    end else begin
      coil_set <= '0;
      coil_reset <= '0;
      bank_sel <= '0;
    end
  end

  assign busy = (state != RMFS_IDLE) || init_sweep;

  // ==========================================================
  // completion interrupt
  // list running flag, so drain of an unwritten list never interrupts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (do_push) begin
      armed <= 1'b1;
    end else if (list_done) begin
      armed <= 1'b0;
    end
  end

  // RULE_08 one irq per list
  // RULE_11 hold until acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_n <= 1'b1;
    end else if (list_done && armed && !do_push) begin
      irq_req_n <= 1'b0;  // completion beats an ack in the same cycle
    end else if (irq_ack || do_push) begin
      irq_req_n <= 1'b1;
    end
  end
endmodule : rmfs_sequencer

// File: rmfs_sequencer_chk.sv
// Purpose: port checks for the relay sequencer
// Assumes: one clock, PULSE_CYC as set by the bench
// Notes: bound at the foot of this file
`timescale 1ns/100ps
module rmfs_sequencer_chk #(
  parameter int PULSE_CYC = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // bus side
  input wire logic wr_strobe,
  input wire logic [3:0] wr_bank,
  input wire logic [15:0] wr_data,
  input wire logic wr_ack,
  input wire logic wr_full,
  input wire logic irq_req_n,
  input wire logic irq_ack,
  // coil side
  input wire logic [15:0] coil_set,
  input wire logic [15:0] coil_reset,
  input wire logic [15:0] bank_sel,
  input wire logic busy
);
  int hi_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // length of the present pulse, zero between pulses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) hi_cnt <= 0;
    else hi_cnt <= (bank_sel != 0) ? hi_cnt + 1 : 0;
  end
  ack_on_take_a: assert property (wr_strobe && !wr_full |=> wr_ack)
    else $error("write not acknowledged");
  no_stray_ack_a: assert property (!(wr_strobe && !wr_full) |=> !wr_ack)
    else $error("ack without stored word");
  coil_idle_a: assert property (bank_sel == 0 |-> (coil_set | coil_reset) == 0)
    else $error("coil driven outside pulse");
  one_bank_a: assert property (bank_sel != 0 |-> $onehot(bank_sel))
    else $error("more than one bank");
  coil_pair_a: assert property (bank_sel != 0 |-> coil_reset == ~coil_set)
    else $error("set and reset coils clash");
  pulse_width_a: assert property ($fell(bank_sel != 0) |-> hi_cnt == PULSE_CYC)
    else $error("pulse width wrong");
  pulse_gap_a: assert property ($fell(bank_sel != 0) |=> bank_sel == 0)
    else $error("gap too short");
  irq_late_a: assert property ($fell(irq_req_n) |-> $past(bank_sel) == 0)
    else $error("irq before last pulse ended");
  irq_hold_a: assert property (!irq_req_n && !irq_ack && !wr_strobe |=> !irq_req_n)
    else $error("irq dropped unacknowledged");
endmodule : rmfs_sequencer_chk
bind rmfs_sequencer rmfs_sequencer_chk #(.PULSE_CYC(PULSE_CYC), .DEPTH(DEPTH)) chk_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .wr_strobe(wr_strobe),
  .wr_bank(wr_bank), .wr_data(wr_data), .wr_ack(wr_ack), .wr_full(wr_full),
  .irq_req_n(irq_req_n), .irq_ack(irq_ack), .coil_set(coil_set),
  .coil_reset(coil_reset), .bank_sel(bank_sel), .busy(busy));

// File: rmfs_cmdr.sv
// Purpose: behavioural bus commander for the sequencer
// Assumes: fifo not full when a word is sent
// Notes: released lines show the inverse of the last value
`timescale 1ns/100ps
module rmfs_cmdr (
  // clock and answer
  input wire logic clk_sys,
  input wire logic wr_ack,
  // requests
  output logic wr_strobe,
  output logic [3:0] wr_bank,
  output logic [15:0] wr_data,
  output logic irq_ack
);
  initial begin
    wr_strobe = 1'b0;
    wr_bank = 4'h0;
    wr_data = 16'h0000;
    irq_ack = 1'b0;
  end
  // one word; data held until the ack edge
  task automatic send(input logic [3:0] b, input logic [15:0] d, output logic a);
    @(posedge clk_sys);
    wr_strobe <= 1'b1;
    wr_bank <= b;
    wr_data <= d;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
    @(negedge clk_sys);
    a = wr_ack;  // ack stands the cycle after the take edge
    @(posedge clk_sys);
    wr_bank <= ~b;
    wr_data <= ~d;
  endtask : send
  task automatic ack();
    @(posedge clk_sys);
    irq_ack <= 1'b1;
    @(posedge clk_sys);
    irq_ack <= 1'b0;
  endtask : ack
endmodule : rmfs_cmdr

// File: rmfs_sequencer_tb_top.sv
// Purpose: self-checking bench for the relay sequencer
// Assumes: short pulse count of 8 cycles
// Notes: the commander model makes every bus request
`timescale 1ns/100ps
module rmfs_sequencer_tb_top;
  logic clk_sys, reset_n, wr_strobe, irq_ack, wr_ack, wr_full, irq_req_n, busy;
  logic [3:0] wr_bank;
  logic [15:0] wr_data, coil_set, coil_reset, bank_sel;
  int error_cnt = 0;
  int num_checks = 0;
  localparam int PULSE = 8;  // short coil pulse keeps the run brief
  rmfs_sequencer #(.PULSE_CYC(PULSE)) rmfs_sequencer_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .wr_strobe(wr_strobe), .wr_bank(wr_bank),
    .wr_data(wr_data), .wr_ack(wr_ack), .wr_full(wr_full),
    .irq_req_n(irq_req_n), .irq_ack(irq_ack), .coil_set(coil_set),
    .coil_reset(coil_reset), .bank_sel(bank_sel), .busy(busy));
  rmfs_cmdr rmfs_cmdr_inst (.clk_sys(clk_sys), .wr_ack(wr_ack),
    .wr_strobe(wr_strobe), .wr_bank(wr_bank), .wr_data(wr_data),
    .irq_ack(irq_ack));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // one pulse: coils and width checked mid-cycle, bank handed back
  task automatic pulse(input logic [15:0] st, rs, output logic [15:0] sel);
    int i;
    int n;
    for (i = 0; i < 300 && bank_sel === 16'h0000; i++) @(negedge clk_sys);
    sel = bank_sel;
    chk("pulse wait", 16'h0000, 16'(i == 300));
    chk("coil_set", st, coil_set);
    chk("coil_reset", rs, coil_reset);
    for (n = 0; n < 300 && bank_sel !== 16'h0000; n++) @(negedge clk_sys);
    chk("width", 16'(PULSE), 16'(n));
    if (i == 300 || n == 300) begin
      complete_run();
    end
  endtask : pulse
  task automatic wait_irq();
    for (int i = 0; i < 60 && irq_req_n !== 1'b0; i++) @(negedge clk_sys);
    chk("irq_req_n", 16'h0000, irq_req_n);
  endtask : wait_irq
  // every bank opened once after reset, no irq
  task automatic t_sweep();
    logic [15:0] s, all;
    all = 16'h0000;
    for (int b = 0; b < 16; b++) begin
      pulse(16'h0000, 16'hFFFF, s);
      all = all | s;
      if (b == 0) begin
        chk("busy sweep", 16'h0001, busy);
      end
    end
    chk("banks", 16'hFFFF, all);
    chk("busy end", 16'h0000, busy);
    chk("irq sweep", 16'h0001, irq_req_n);
  endtask : t_sweep
  // two words, two pulses in order, one irq held
  task automatic t_list();
    logic [15:0] s;
    logic a;
    rmfs_cmdr_inst.send(4'h3, 16'hA5C3, a);
    chk("ack", 16'h0001, a);
    chk("full", 16'h0000, wr_full);
    rmfs_cmdr_inst.send(4'hC, 16'h0F01, a);
    chk("ack", 16'h0001, a);
    pulse(16'hA5C3, 16'h5A3C, s);
    chk("sel", 16'h0008, s);
    chk("irq mid", 16'h0001, irq_req_n);
    pulse(16'h0F01, 16'hF0FE, s);
    chk("sel", 16'h1000, s);
    chk("busy list", 16'h0001, busy);
    wait_irq();
    chk("busy done", 16'h0000, busy);
    repeat (5) @(posedge clk_sys);
    chk("irq held", 16'h0000, irq_req_n);
  endtask : t_list
  // write clears pending irq, then ack clears the next
  task automatic t_clear();
    logic [15:0] s;
    logic a;
    rmfs_cmdr_inst.send(4'hF, 16'hFFFF, a);
    @(negedge clk_sys);
    chk("irq clr", 16'h0001, irq_req_n);
    chk("ack", 16'h0001, a);
    pulse(16'hFFFF, 16'h0000, s);
    chk("sel", 16'h8000, s);
    wait_irq();
    rmfs_cmdr_inst.ack();
    @(negedge clk_sys);
    chk("irq ack", 16'h0001, irq_req_n);
  endtask : t_clear
  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_sweep();
    t_list();
    t_clear();
    complete_run();
  end
endmodule : rmfs_sequencer_tb_top
